// File: rtl/cscpkg.sv
package cscpkg;
  // ==========================================================
  // source field codes
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h2;
  // ==========================================================
  // request and event bit positions
  localparam int REQ_CPU = 0;
  localparam int REQ_SLOWEST = 1;
  localparam int REQ_MID = 2;
  localparam int REQ_TOP = 3;
  localparam int EV_FAST = 0;
  localparam int EV_SLOW = 1;
  localparam int EV_DONE = 2;
  localparam int EV_TMO = 3;
  localparam int NUM_EV = 4;
  localparam int IV_W = 7;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CAL_TIME_NS = 1600;
  localparam int CAL_CYC = (CAL_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int CAL_W = 8;
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYC - 1);
  localparam logic [CAL_W-1:0] CAL_ZERO = 8'h00;
  localparam logic [IV_W-1:0] IV_ZERO = 7'h00;
  localparam logic [IV_W-1:0] IV_ONE = 7'h01;
  // ==========================================================
  // slow controller states, gray along off-warm-run
  typedef enum logic [1:0] {
    CSC_SL_OFF = 2'h0,
    CSC_SL_WARM = 2'h1,
    CSC_SL_RUN = 2'h3
  } csc_slow_e;
endpackage : cscpkg

// File: rtl/csc_sync3.sv
module csc_sync3 (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // async level in, filtered level out
  input wire logic async_i,
  output logic level_o
);
  logic s1_reg, s2_reg, s3_reg, lvl_reg;
  logic lvl_next;

  always_comb begin
    // change accepted only once stage two and three agree
    lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;
endmodule : csc_sync3

// File: rtl/csc_clock_ctrl.sv
module csc_clock_ctrl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // system power state and fast clock requests
  input wire logic system_on_i,
  input wire logic [3:0] fast_req_i,
  // analog oscillator status, asynchronous
  input wire logic fast_xtal_ready_i,
  input wire logic slow_xtal_ready_i,
  input wire logic slow_clock_tick_i,
  // task pulses
  input wire logic fast_xtal_start_task_i,
  input wire logic fast_xtal_stop_task_i,
  input wire logic slow_clock_start_task_i,
  input wire logic slow_clock_stop_task_i,
  input wire logic cal_task_i,
  input wire logic cal_timer_start_task_i,
  input wire logic cal_timer_stop_task_i,
  // configuration
  input wire logic [1:0] source_field_i,
  input wire logic slow_external_i,
  input wire logic slow_bypass_i,
  input wire logic [6:0] cal_timer_interval_i,
  input wire logic [3:0] event_clear_i,
  // fast clock outputs
  output logic cpu_fast_clock_en_o,
  output logic periph_clock_slowest_en_o,
  output logic periph_clock_mid_en_o,
  output logic periph_clock_top_en_o,
  output logic fast_internal_osc_en_o,
  output logic fast_crystal_osc_en_o,
  output logic fast_src_crystal_o,
  // slow clock outputs
  output logic slow_rc_osc_en_o,
  output logic slow_crystal_osc_en_o,
  output logic slow_synth_clock_en_o,
  output logic [1:0] slow_clock_status_src_o,
  output logic slow_clock_status_running_o,
  output logic cal_busy_o,
  output logic cal_timer_running_o,
  // sticky events
  output logic [3:0] events_o
);
  // ==========================================================
  // synchronisers
  logic fx_rdy, sx_rdy, tick_lvl;
  csc_sync3 u_sync_fx (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .async_i(fast_xtal_ready_i), .level_o(fx_rdy));
  csc_sync3 u_sync_sx (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .async_i(slow_xtal_ready_i), .level_o(sx_rdy));
  csc_sync3 u_sync_tk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .async_i(slow_clock_tick_i), .level_o(tick_lvl));

  // ==========================================================
  // state
  cscpkg::csc_slow_e sl_reg, sl_next;
  logic [1:0] src_reg, src_next;
  logic fxo_reg, fxo_next, fsrc_reg, fsrc_next;
  logic [3:0] clk_en_reg, clk_en_next;
  logic fast_internal_osc_reg, fast_internal_osc_next;
  logic rc_reg, rc_next, lx_reg, lx_next, syn_reg, syn_next;
  logic cal_reg, cal_next;
  logic run_reg, run_next;
  logic [cscpkg::CAL_W-1:0] calc_reg, calc_next;
  logic ct_reg, ct_next;
  logic [cscpkg::IV_W-1:0] ctc_reg, ctc_next;
  logic tick_d_reg;
  logic [3:0] ev_reg, ev_next;
  logic [3:0] ev_set;
  logic tick;

  always_comb begin
    tick = tick_lvl & ~tick_d_reg;
    sl_next = sl_reg;
    src_next = src_reg;
    fxo_next = fxo_reg;
    cal_next = cal_reg;
    calc_next = calc_reg;
    ct_next = ct_reg;
    ctc_next = ctc_reg;
    ev_set = 4'h0;
    // fast crystal tasks, stop wins on collision
    if (fast_xtal_start_task_i) begin
      fxo_next = 1'b1;
    end
    if (fast_xtal_stop_task_i || !system_on_i) begin
      fxo_next = 1'b0;
    end
    // event only when crystal on and stable
    fsrc_next = fxo_reg & fx_rdy & system_on_i;
    ev_set[cscpkg::EV_FAST] = fsrc_next & ~fsrc_reg;
    // slow controller
    case (sl_reg)
      cscpkg::CSC_SL_OFF: begin
        if (slow_clock_start_task_i) begin
          src_next = source_field_i;
          // crystal warms up behind the rc source
          sl_next = (source_field_i == cscpkg::SRC_XTAL) ?
            cscpkg::CSC_SL_WARM : cscpkg::CSC_SL_RUN;
          ev_set[cscpkg::EV_SLOW] =
            (source_field_i != cscpkg::SRC_XTAL);
        end
      end
      cscpkg::CSC_SL_WARM: begin
        if (sx_rdy) begin
          sl_next = cscpkg::CSC_SL_RUN;
          ev_set[cscpkg::EV_SLOW] = 1'b1;
        end
      end
      cscpkg::CSC_SL_RUN: begin
      end
      default: sl_next = cscpkg::CSC_SL_OFF;
    endcase
    if (slow_clock_stop_task_i && sl_reg != cscpkg::CSC_SL_OFF) begin
      sl_next = cscpkg::CSC_SL_OFF;
    end
    if (!system_on_i) begin
      sl_next = cscpkg::CSC_SL_OFF;
    end
    // calibration: rc running as the slow source
    if (cal_reg) begin
      calc_next = calc_reg - 1'b1;
      if (calc_reg == cscpkg::CAL_ZERO) begin
        cal_next = 1'b0;
        ev_set[cscpkg::EV_DONE] = 1'b1;
      end
    end else if (cal_task_i && sl_reg == cscpkg::CSC_SL_RUN &&
                 src_reg == cscpkg::SRC_RC) begin
      cal_next = 1'b1;
      calc_next = cscpkg::CAL_LAST;
    end
    if (sl_next == cscpkg::CSC_SL_OFF) begin
      cal_next = 1'b0;
    end
    // calibration timer, counts slow clock ticks
    if (cal_timer_start_task_i) begin
      ct_next = 1'b1;
      ctc_next = cal_timer_interval_i;
    end else if (cal_timer_stop_task_i) begin
      ct_next = 1'b0;
    end else if (ct_reg && tick) begin
      if (ctc_reg <= cscpkg::IV_ONE) begin
        ctc_next = cscpkg::IV_ZERO;
        ct_next = 1'b0;
        ev_set[cscpkg::EV_TMO] = 1'b1;
      end else begin
        ctc_next = ctc_reg - cscpkg::IV_ONE;
      end
    end
    // set wins over clear
    ev_next = (ev_reg & ~event_clear_i) | ev_set;
    // fast clock tree, gated to on state
    clk_en_next = system_on_i ? fast_req_i : 4'h0;
    // internal osc unless crystal is the source
    fast_internal_osc_next = system_on_i & ~fsrc_next &
      ((|fast_req_i) | cal_next |
       (src_next == cscpkg::SRC_SYNTH &&
        sl_next != cscpkg::CSC_SL_OFF));
    // slow oscillator enables
    rc_next = (sl_next == cscpkg::CSC_SL_WARM) |
      (sl_next == cscpkg::CSC_SL_RUN &&
       src_next == cscpkg::SRC_RC);
    lx_next = (sl_next != cscpkg::CSC_SL_OFF) &&
      src_next == cscpkg::SRC_XTAL;
    syn_next = (sl_next == cscpkg::CSC_SL_RUN) &&
      src_next == cscpkg::SRC_SYNTH;
    // running status registered so the port comes from a flop
    run_next = (sl_next == cscpkg::CSC_SL_RUN);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sl_reg <= cscpkg::CSC_SL_OFF;
      src_reg <= cscpkg::SRC_RC;
      fxo_reg <= 1'b0;
      fsrc_reg <= 1'b0;
      clk_en_reg <= 4'h0;
      fast_internal_osc_reg <= 1'b0;
      rc_reg <= 1'b0;
      lx_reg <= 1'b0;
      syn_reg <= 1'b0;
      run_reg <= 1'b0;
      cal_reg <= 1'b0;
      calc_reg <= cscpkg::CAL_ZERO;
      ct_reg <= 1'b0;
      ctc_reg <= cscpkg::IV_ZERO;
      tick_d_reg <= 1'b0;
      ev_reg <= 4'h0;
    end else begin
      sl_reg <= sl_next;
      src_reg <= src_next;
      fxo_reg <= fxo_next;
      fsrc_reg <= fsrc_next;
      clk_en_reg <= clk_en_next;
      fast_internal_osc_reg <= fast_internal_osc_next;
      rc_reg <= rc_next;
      lx_reg <= lx_next;
      syn_reg <= syn_next;
      run_reg <= run_next;
      cal_reg <= cal_next;
      calc_reg <= calc_next;
      ct_reg <= ct_next;
      ctc_reg <= ctc_next;
      tick_d_reg <= tick_lvl;
      ev_reg <= ev_next;
    end
  end

  // ==========================================================
  // outputs
  assign cpu_fast_clock_en_o = clk_en_reg[cscpkg::REQ_CPU];
  assign periph_clock_slowest_en_o = clk_en_reg[cscpkg::REQ_SLOWEST];
  assign periph_clock_mid_en_o = clk_en_reg[cscpkg::REQ_MID];
  assign periph_clock_top_en_o = clk_en_reg[cscpkg::REQ_TOP];
  assign fast_internal_osc_en_o = fast_internal_osc_reg;
  assign fast_crystal_osc_en_o = fxo_reg;
  assign fast_src_crystal_o = fsrc_reg;
  assign slow_rc_osc_en_o = rc_reg;
  assign slow_crystal_osc_en_o = lx_reg;
  assign slow_synth_clock_en_o = syn_reg;
  assign slow_clock_status_src_o = src_reg;
  assign slow_clock_status_running_o = run_reg;
  assign cal_busy_o = cal_reg;
  assign cal_timer_running_o = ct_reg;
  assign events_o = ev_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_start_xtal;
    sl_reg == cscpkg::CSC_SL_OFF && slow_clock_start_task_i &&
      source_field_i == cscpkg::SRC_XTAL && system_on_i &&
      !slow_clock_stop_task_i;
  endsequence
  sequence s_warm_on_rc;
    rc_reg && lx_reg && !slow_clock_status_running_o;
  endsequence

  a_fast_req_served: assert property (
    system_on_i |=> clk_en_reg == $past(fast_req_i))
    else $error("fast clock enable does not follow request");
  a_off_no_fast: assert property (
    !system_on_i |=> clk_en_reg == 4'h0 && !fxo_reg)
    else $error("fast clocks alive outside on state");
  a_fast_internal_osc_used: assert property (
    system_on_i && (|fast_req_i) && !fxo_reg |=> fast_internal_osc_reg)
    else $error("internal osc not serving request");
  a_xtal_task: assert property (
    fast_xtal_stop_task_i |=> !fxo_reg)
    else $error("crystal did not stop");
  a_fast_event: assert property (
    $rose(ev_reg[cscpkg::EV_FAST]) |-> fsrc_reg)
    else $error("fast event before stable crystal");
  a_xtal_warm: assert property (
    s_start_xtal ##1 !sx_rdy |-> s_warm_on_rc)
    else $error("crystal start not run from rc");
  a_slow_stop: assert property (
    slow_clock_stop_task_i |=> sl_reg == cscpkg::CSC_SL_OFF)
    else $error("slow clock did not stop");
  a_off_slow: assert property (
    !system_on_i |=> !rc_reg && !lx_reg && !syn_reg)
    else $error("slow source on in off state");
  a_cal_done: assert property (
    $rose(cal_reg) |-> cal_reg[*8] ##[1:20] ev_reg[cscpkg::EV_DONE])
    else $error("calibration done event missing");
  a_timer_zero: assert property (
    $fell(ct_reg) && !$past(cal_timer_stop_task_i) |->
      ev_reg[cscpkg::EV_TMO] && ctc_reg == cscpkg::IV_ZERO)
    else $error("timer stopped without timeout");
  a_event_sticky: assert property (
    ev_reg[cscpkg::EV_SLOW] && !event_clear_i[cscpkg::EV_SLOW] |=>
      ev_reg[cscpkg::EV_SLOW])
    else $error("event flag lost");
endmodule : csc_clock_ctrl

// File: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    string name;
    logic [18:0] mask;
    logic [18:0] val;
  } csc_note_s;
  // ==========================================================
  // stimulus and observation
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic system_on_i = 1'b1;
  logic [3:0] fast_req_i = 4'h0;
  logic fx_rdy = 1'b0;
  logic sx_rdy = 1'b0;
  logic tick = 1'b0;
  logic [6:0] task_v = 7'h00;
  logic [1:0] src = 2'h0;
  logic ext = 1'b0;
  logic byp = 1'b0;
  logic [6:0] iv = 7'h00;
  logic [3:0] clr = 4'h0;
  wire [18:0] obs;
  logic [1:0] src_tab[2] = '{2'h0, 2'h2};
  logic [1:0] xtal_tab[3] = '{2'h0, 2'h2, 2'h3};
  csc_note_s exp_q[$];
  event note_ev;
  int bad_count = 0;
  int compares = 0;
  int n;
  always #50 clk_sys_i = ~clk_sys_i;
  csc_clock_ctrl csc_clock_ctrl_i (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .system_on_i(system_on_i), .fast_req_i(fast_req_i),
    .fast_xtal_ready_i(fx_rdy), .slow_xtal_ready_i(sx_rdy),
    .slow_clock_tick_i(tick),
    .fast_xtal_start_task_i(task_v[0]), .fast_xtal_stop_task_i(task_v[1]),
    .slow_clock_start_task_i(task_v[2]), .slow_clock_stop_task_i(task_v[3]),
    .cal_task_i(task_v[4]), .cal_timer_start_task_i(task_v[5]),
    .cal_timer_stop_task_i(task_v[6]),
    .source_field_i(src), .slow_external_i(ext), .slow_bypass_i(byp),
    .cal_timer_interval_i(iv), .event_clear_i(clr),
    .cpu_fast_clock_en_o(obs[0]), .periph_clock_slowest_en_o(obs[1]),
    .periph_clock_mid_en_o(obs[2]), .periph_clock_top_en_o(obs[3]),
    .fast_internal_osc_en_o(obs[4]), .fast_crystal_osc_en_o(obs[5]),
    .fast_src_crystal_o(obs[6]), .slow_rc_osc_en_o(obs[7]),
    .slow_crystal_osc_en_o(obs[8]), .slow_synth_clock_en_o(obs[9]),
    .slow_clock_status_src_o(obs[11:10]),
    .slow_clock_status_running_o(obs[12]), .cal_busy_o(obs[13]),
    .cal_timer_running_o(obs[14]), .events_o(obs[18:15])
  );
  // ==========================================================
  // checking: monitor drains notes against live outputs
  task check(input string name, input logic [18:0] seen,
             input logic [18:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  always @(note_ev) begin
    while (exp_q.size() != 0) begin
      csc_note_s nt;
      nt = exp_q.pop_front();
      check(nt.name, obs & nt.mask, nt.val & nt.mask);
    end
  end
  task expect_o(input string name, input logic [18:0] mask,
                input logic [18:0] val);
    exp_q.push_back('{name, mask, val});
    ->note_ev;
    #1;
  endtask : expect_o
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // drivers, all at the falling edge
  task pulse(input int k);
    @(negedge clk_sys_i) task_v[k] = 1'b1;
    @(negedge clk_sys_i) task_v[k] = 1'b0;
  endtask : pulse
  task clear_ev(input int k);
    @(negedge clk_sys_i) clr[k] = 1'b1;
    @(negedge clk_sys_i) clr[k] = 1'b0;
  endtask : clear_ev
  // bounded wait, outcome judged by the following expect
  task wait_for(input int idx, input logic v, input int lim);
    n = 0;
    while (obs[idx] !== v && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask : wait_for
  // slow ticks wide enough for the three-flop input filter
  task slow_tick;
    @(negedge clk_sys_i) tick = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    tick = 1'b0;
    repeat (10) @(negedge clk_sys_i);
  endtask : slow_tick
  initial begin
    #3_000_000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(10348));
    repeat (5) @(negedge clk_sys_i);
    expect_o("reset outputs", '1, '0);
    reset_n_i = 1'b1;
    // fast clock requests, random mixes
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_sys_i) fast_req_i = 4'($urandom_range(1, 15));
      @(negedge clk_sys_i);
      expect_o("fast enables", 19'h0005f, {13'h0, 2'h1, fast_req_i});
    end
    @(negedge clk_sys_i) fast_req_i = 4'h0;
    @(negedge clk_sys_i);
    expect_o("power save", 19'h0001f, '0);
    $display("test fast requests done");
    // fast crystal start, stabilise, clear event
    pulse(0);
    expect_o("xtal started early", 19'h08060, 19'h00020);
    fx_rdy = 1'b1;
    wait_for(15, 1'b1, 12);
    expect_o("xtal stable", 19'h08060, 19'h08060);
    clear_ev(0);
    expect_o("event cleared", 19'h08000, '0);
    $display("test fast crystal done");
    // slow rc and synth sources
    foreach (src_tab[j]) begin
      src = src_tab[j];
      pulse(2);
      expect_o("slow start", 19'h11f80,
        {2'h0, 1'b1, 3'h0, 1'b1, src, src == 2'h2, 1'b0, src == 2'h0,
         7'h0});
      clear_ev(1);
      pulse(3);
      expect_o("slow stop", 19'h11380, '0);
    end
    // slow crystal warms on rc, then hands over
    src = 2'h1;
    {ext, byp} = xtal_tab[$urandom_range(0, 2)];
    pulse(2);
    expect_o("crystal warm", 19'h11380, 19'h00580);
    sx_rdy = 1'b1;
    wait_for(16, 1'b1, 12);
    expect_o("crystal run", 19'h11380, 19'h11500);
    clear_ev(1);
    pulse(3);
    {ext, byp} = 2'h0;
    $display("test slow sources done");
    // calibration refused when off, then full run on rc
    pulse(4);
    expect_o("cal refused", 19'h02000, '0);
    src = 2'h0;
    pulse(2);
    slow_tick();
    pulse(4);
    expect_o("cal busy", 19'h22000, 19'h02000);
    wait_for(13, 1'b0, 40);
    expect_o("cal done", 19'h22000, 19'h20000);
    $display("test calibration done");
    // calibration timer: full count then early stop
    iv = 7'($urandom_range(2, 5));
    slow_tick();
    pulse(5);
    expect_o("timer run", 19'h44000, 19'h04000);
    repeat (iv - 1) slow_tick();
    expect_o("timer counting", 19'h44000, 19'h04000);
    slow_tick();
    expect_o("timer timeout", 19'h44000, 19'h40000);
    clear_ev(3);
    pulse(5);
    slow_tick();
    pulse(6);
    expect_o("timer stopped", 19'h44000, '0);
    $display("test timer done");
    // fast crystal stop task, source flag follows a cycle later
    pulse(1);
    @(negedge clk_sys_i);
    expect_o("xtal stopped", 19'h00060, '0);
    // power off drops clock enables, oscillator enables and slow running status
    fast_req_i = 4'hf;
    @(negedge clk_sys_i) system_on_i = 1'b0;
    @(negedge clk_sys_i);
    expect_o("off state", 19'h017ff, '0);
    $display("test off state done");
    report_and_stop();
  end
endmodule : tb_top
